// >>> rtl/lcd_frame_sync.sv
// Segment LCD control: registers, frame interrupt, write window and Sleep.
// Assumes a single-cycle register port on CLOCK and a SLEEP level from the
// core on the same clock.
//
// Overview of operation
// - A frame begins at the leading edge of the first common line.
// - Frame flag sets right after the last pixel row of a frame is fetched.
// - Type-B raises the frame flag only at ends of complete phase intervals.
// - A pixel write while writing is disabled sets the write-error flag.
// - No frame flag for Type-A, nor for Type-B with static drive.
// - Sleep-enable set stops the module in Sleep; clear keeps it running unless the system clock is the source.
// - Halting on Sleep drives minimum level on all segment and common lines.
// - Sleep-enable clear with a non-system source keeps refreshing the panel.
// - Pixel data cannot change while the processor sleeps.
// - System clock as source stops the module on Sleep regardless of enable.
// - Regulator bias modes 1, 2, 3 give no software contrast control.
// - Type-A alternates phase within a slot for static and 1/2 multiplex, Type-B at frame boundaries.
// - Common count field selects static, 1/2, 1/3 or 1/4 multiplex.
`timescale 1ns/100ps
`default_nettype none
module lcd_frame_sync (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port.
  input wire logic [5:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Processor power state.
  input wire logic SLEEP,
  // Panel drive.
  output logic [47:0] SEG_OUT,
  output logic [3:0] COM_OUT,
  output logic WAVE_POL,
  output logic DRIVE_MIN,
  // Interrupt request and bias status.
  output logic FRAME_IRQ,
  output logic FRAME_IRQ_HIPRI,
  output logic SOFT_CONTRAST
);

  typedef struct packed {
    lcd_pkg::lcd_st_e st;
    logic [7:0] ctl;
    logic [7:0] ps;
    logic [7:0] bias;
    logic [7:0] irqf;
    logic [7:0] irqe;
    logic [7:0] irqp;
    logic [5:0][7:0] sege;
    logic [23:0][7:0] pix;
    logic [5:0][7:0] row;
    logic win;
    logic [7:0] rdata;
    logic [47:0] seg;
    logic [3:0] com;
    logic pol;
    logic dmin;
    logic irq;
    logic pri;
    logic ctr;
  } top_s;

  top_s s;
  top_s n;
  logic run;
  logic typeb_mux;
  logic pix_wr;
  logic [4:0] pix_idx;
  logic wr_ok;
  logic irq_set;
  logic pol;

  lcd_timing_if tim ();

  // Pixel register address decode, shared by the write path and the read path.
  function automatic logic pix_hit(input logic [5:0] a);
    return (a >= lcd_pkg::A_PIX) && (a < lcd_pkg::A_PIX_END);
  endfunction : pix_hit

  // ==========================================================================
  // Frame timer.
  lcd_frame_timer u_timer (
    .clock(CLOCK),
    .rst_n(RST_N),
    .t(tim.gen)
  );

  // Timer controls come straight from the registers.
  assign tim.run = (s.st == lcd_pkg::ST_RUN);
  assign tim.lp = s.ps[3:0];
  assign tim.cc = s.ctl[1:0];

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    n = s;
    run = (s.st == lcd_pkg::ST_RUN);
    // Pairing only matters for multiplexed Type-B drive.
    typeb_mux = s.ps[lcd_pkg::PS_WFT] && (s.ctl[1:0] != 2'h0);
    pix_wr = WR && pix_hit(ADDR);
    pix_idx = 5'(ADDR - lcd_pkg::A_PIX);
    // Pixel writes are shut during Sleep and outside the Type-B window.
    wr_ok = !SLEEP && !(run && typeb_mux && !s.win);
    // The flag follows the fetch of the last row of the odd frame of a pair.
    irq_set = run && tim.slot_start && typeb_mux && tim.frame_odd
      && (tim.com_idx == s.ctl[1:0]);
    pol = s.ps[lcd_pkg::PS_WFT] ? tim.frame_odd : tim.sub_hi;

    // Module state. A system-clock source cannot run through Sleep.
    case (s.st)
      lcd_pkg::ST_OFF: begin
        if (s.ctl[lcd_pkg::CTL_EN]) begin
          n.st = lcd_pkg::ST_RUN;
        end
      end
      lcd_pkg::ST_RUN: begin
        if (!s.ctl[lcd_pkg::CTL_EN]) begin
          n.st = lcd_pkg::ST_OFF;
        end else if (SLEEP && (s.ctl[lcd_pkg::CTL_SLP]
            || s.ctl[3:2] == lcd_pkg::CS_SYS)) begin
          n.st = lcd_pkg::ST_HALT;
        end
      end
      lcd_pkg::ST_HALT: begin
        if (!s.ctl[lcd_pkg::CTL_EN]) begin
          n.st = lcd_pkg::ST_OFF;
        end else if (!SLEEP) begin
          n.st = lcd_pkg::ST_RUN;
        end
      end
      default: begin
        n.st = lcd_pkg::ST_OFF;
      end
    endcase

    // Row fetch at the start of each common slot.
    if (run && tim.slot_start) begin
      for (int i = 0; i < 6; i++) begin
        n.row[i] = s.pix[5'(tim.com_idx) * 5'h06 + 5'(i)];
      end
    end

    // Write window: opens with the flag, closes when the next frame's fetch
    // begins, so pixel data stays fixed across a Type-B pair.
    if (run && tim.slot_start && tim.com_idx == 2'h0) begin
      n.win = 1'b0;
    end
    if (irq_set) begin
      n.win = 1'b1;
    end
    if (!run) begin
      n.win = 1'b0;
    end

    // Register writes. Flags clear only by writing a zero to them.
    if (WR) begin
      if (ADDR == lcd_pkg::A_CTL) begin
        n.ctl = WDATA & lcd_pkg::CTL_MASK;
        n.ctl[lcd_pkg::CTL_WRITE_ERROR_FLAG] = s.ctl[lcd_pkg::CTL_WRITE_ERROR_FLAG] & WDATA[lcd_pkg::CTL_WRITE_ERROR_FLAG];
      end else if (ADDR == lcd_pkg::A_PS) begin
        n.ps = WDATA & lcd_pkg::PS_MASK;
      end else if (ADDR == lcd_pkg::A_REG) begin
        n.bias = WDATA & lcd_pkg::REG_MASK;
      end else if (ADDR == lcd_pkg::A_IRQF) begin
        n.irqf = s.irqf & WDATA & lcd_pkg::IRQ_MASK;
      end else if (ADDR == lcd_pkg::A_IRQE) begin
        n.irqe = WDATA & lcd_pkg::IRQ_MASK;
      end else if (ADDR == lcd_pkg::A_IRQP) begin
        n.irqp = WDATA & lcd_pkg::IRQ_MASK;
      end else if (ADDR >= lcd_pkg::A_SEGE && ADDR < lcd_pkg::A_SEGE_END) begin
        n.sege[3'(ADDR - lcd_pkg::A_SEGE)] = WDATA;
      end else if (pix_wr && wr_ok) begin
        n.pix[pix_idx] = WDATA;
      end
    end

    // Hardware sets come last so an event beats a clear in the same cycle.
    if (pix_wr && !wr_ok) begin
      n.ctl[lcd_pkg::CTL_WRITE_ERROR_FLAG] = 1'b1;
    end
    if (irq_set) begin
      n.irqf[lcd_pkg::IRQ_BIT] = 1'b1;
    end

    // Read data, valid the cycle after the strobe; unmapped reads give zero.
    n.rdata = lcd_pkg::BYTE_RST;
    if (RD) begin
      if (ADDR == lcd_pkg::A_CTL) begin
        n.rdata = s.ctl;
      end else if (ADDR == lcd_pkg::A_PS) begin
        n.rdata = {s.ps[7:6], run, wr_ok, s.ps[3:0]};
      end else if (ADDR == lcd_pkg::A_REG) begin
        n.rdata = s.bias;
      end else if (ADDR == lcd_pkg::A_IRQF) begin
        n.rdata = s.irqf;
      end else if (ADDR == lcd_pkg::A_IRQE) begin
        n.rdata = s.irqe;
      end else if (ADDR == lcd_pkg::A_IRQP) begin
        n.rdata = s.irqp;
      end else if (ADDR >= lcd_pkg::A_SEGE && ADDR < lcd_pkg::A_SEGE_END) begin
        n.rdata = s.sege[3'(ADDR - lcd_pkg::A_SEGE)];
      end else if (pix_hit(ADDR)) begin
        n.rdata = s.pix[pix_idx];
      end
    end

    // Panel drive. Anything but running drives the minimum level on every
    // line; the analog stage maps zero codes to that level.
    n.seg = run ? ((n.row ^ {48{pol}}) & s.sege) : 48'h0000_0000_0000;
    n.com = run ? (4'h1 << tim.com_idx) : 4'h0;
    n.pol = run & pol;
    n.dmin = !run;
    n.irq = s.irqf[lcd_pkg::IRQ_BIT] & s.irqe[lcd_pkg::IRQ_BIT];
    n.pri = s.irqp[lcd_pkg::IRQ_BIT];
    // Only the resistor ladder mode leaves contrast to the software field.
    n.ctr = (s.bias[1:0] == 2'h0) && !s.bias[lcd_pkg::REG_CHARGE_PUMP_ENABLE];
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.st <= lcd_pkg::ST_OFF;
      s.dmin <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register.
  assign RDATA = s.rdata;
  assign SEG_OUT = s.seg;
  assign COM_OUT = s.com;
  assign WAVE_POL = s.pol;
  assign DRIVE_MIN = s.dmin;
  assign FRAME_IRQ = s.irq;
  assign FRAME_IRQ_HIPRI = s.pri;
  assign SOFT_CONTRAST = s.ctr;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  frame_start_a: assert property (
    tim.slot_start && tim.com_idx == 2'h0 && run && s.ctl[lcd_pkg::CTL_EN] && !SLEEP
    |=> COM_OUT == 4'h1)
    else $error("Frame did not start on the first common line.");

  frame_flag_a: assert property (
    tim.slot_start && run && s.ps[lcd_pkg::PS_WFT] && s.ctl[1:0] != 2'h0
    && tim.frame_odd && tim.com_idx == s.ctl[1:0]
    |=> s.irqf[lcd_pkg::IRQ_BIT] && s.win)
    else $error("Frame flag or window missing after last fetch.");

  pair_only_a: assert property (
    $rose(s.irqf[lcd_pkg::IRQ_BIT]) |-> $past(tim.frame_odd) && $past(tim.slot_start))
    else $error("Frame flag raised off a complete phase interval.");

  no_flag_a: assert property (
    !typeb_mux |=> !$rose(s.irqf[lcd_pkg::IRQ_BIT]))
    else $error("Frame flag raised without multiplexed Type-B drive.");

  write_error_a: assert property (
    pix_wr && !wr_ok |=> s.ctl[lcd_pkg::CTL_WRITE_ERROR_FLAG] ##1 s.ctl[lcd_pkg::CTL_WRITE_ERROR_FLAG]
    || $past(WR && ADDR == lcd_pkg::A_CTL))
    else $error("Write error flag not set or not held.");

  blocked_write_a: assert property (
    pix_wr && !wr_ok |=> $stable(s.pix))
    else $error("Blocked write changed pixel data.");

  sleep_write_a: assert property (
    SLEEP && pix_wr |=> s.pix == $past(s.pix))
    else $error("Pixel data changed during Sleep.");

  halt_drive_a: assert property (
    s.st == lcd_pkg::ST_HALT |=> DRIVE_MIN && SEG_OUT == 48'h0000_0000_0000 && COM_OUT == 4'h0)
    else $error("Lines not at minimum level while halted.");

  sleep_run_a: assert property (
    run && s.ctl[lcd_pkg::CTL_EN] && SLEEP && !s.ctl[lcd_pkg::CTL_SLP]
    && s.ctl[3:2] != lcd_pkg::CS_SYS |=> run [*2] or (run ##1 !SLEEP) or !s.ctl[lcd_pkg::CTL_EN])
    else $error("Module stopped in Sleep with sleep enable clear.");

  sys_stop_a: assert property (
    run && s.ctl[lcd_pkg::CTL_EN] && SLEEP && s.ctl[3:2] == lcd_pkg::CS_SYS
    |=> s.st == lcd_pkg::ST_HALT ##1 DRIVE_MIN)
    else $error("System clock source did not stop on Sleep.");

  contrast_a: assert property (
    SOFT_CONTRAST |-> $past(s.bias[1:0] == 2'h0 && !s.bias[lcd_pkg::REG_CHARGE_PUMP_ENABLE]))
    else $error("Software contrast offered in a regulator mode.");

  irq_gate_a: assert property (
    FRAME_IRQ |-> $past(s.irqf[lcd_pkg::IRQ_BIT] && s.irqe[lcd_pkg::IRQ_BIT]))
    else $error("Interrupt request without flag and enable.");

endmodule : lcd_frame_sync
`default_nettype wire

// >>> rtl/lcd_pkg.sv
// Shared constants, state codes and field positions for the LCD frame sync block.
// Assumes an 8-bit register port with byte-wide registers at 6-bit addresses.
package lcd_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [5:0] A_CTL = 6'h00;
  localparam logic [5:0] A_PS = 6'h01;
  localparam logic [5:0] A_REG = 6'h02;
  localparam logic [5:0] A_IRQF = 6'h03;
  localparam logic [5:0] A_IRQE = 6'h04;
  localparam logic [5:0] A_IRQP = 6'h05;
  localparam logic [5:0] A_SEGE = 6'h08;
  localparam logic [5:0] A_SEGE_END = 6'h0E;
  localparam logic [5:0] A_PIX = 6'h10;
  localparam logic [5:0] A_PIX_END = 6'h28;

  // ==========================================================================
  // Field positions, masks and values after reset.
  localparam int CTL_EN = 7;
  localparam int CTL_SLP = 6;
  localparam int CTL_WRITE_ERROR_FLAG = 5;
  localparam logic [7:0] CTL_MASK = 8'hEF;
  localparam logic [7:0] PS_MASK = 8'hCF;
  localparam logic [7:0] REG_MASK = 8'h7F;
  localparam int PS_WFT = 7;
  localparam int REG_CHARGE_PUMP_ENABLE = 6;
  localparam int IRQ_BIT = 6;
  localparam logic [7:0] IRQ_MASK = 8'h40;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] CS_SYS = 2'h0;

  // ==========================================================================
  // Timing source divider: core clock down to the nominal display source rate.
  localparam int CLK_HZ = 25_000_000;
  localparam int SRC_HZ = 31_250;
  localparam logic [9:0] SRC_DIV_LAST = 10'(CLK_HZ / SRC_HZ - 1);

  // ==========================================================================
  // Module states, one-hot.
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_RUN = 3'h2,
    ST_HALT = 3'h4
  } lcd_st_e;

  // Last sub-phase index of one common slot for each common count.
  function automatic logic [1:0] sub_last(input logic [1:0] cc);
    case (cc)
      2'h0: return 2'h3;
      2'h1: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction : sub_last

endpackage : lcd_pkg

// >>> rtl/lcd_timing_if.sv
// Carrier between the control block and its frame timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface lcd_timing_if;
  logic run;
  logic [3:0] lp;
  logic [1:0] cc;
  logic slot_start;
  logic [1:0] com_idx;
  logic sub_hi;
  logic frame_odd;
  modport gen (input run, lp, cc, output slot_start, com_idx, sub_hi, frame_odd);
  modport ctl (output run, lp, cc, input slot_start, com_idx, sub_hi, frame_odd);
endinterface : lcd_timing_if
`default_nettype wire

// >>> rtl/lcd_frame_timer.sv
// Frame timer: source divider, frame prescaler, sub-phase and common counters.
// Assumes run, lp and cc come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module lcd_frame_timer (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Timing carrier.
  lcd_timing_if.gen t
);

  typedef struct packed {
    logic live;
    logic [9:0] pre;
    logic [3:0] lpc;
    logic [1:0] sub;
    logic [1:0] com;
    logic odd;
    logic slot;
  } tim_s;

  tim_s s;
  tim_s n;

  // ==========================================================================
  // Counter chain. A stopped timer restarts at the first common, so a wake
  // from a Sleep that halted the module always begins a clean frame.
  always_comb begin
    n = s;
    n.slot = 1'b0;
    if (!t.run) begin
      n = '0;
    end else if (!s.live) begin
      n.live = 1'b1;
      n.slot = 1'b1;
    end else if (s.pre != lcd_pkg::SRC_DIV_LAST) begin
      n.pre = s.pre + 10'h001;
    end else begin
      n.pre = 10'h000;
      if (s.lpc != t.lp) begin
        n.lpc = s.lpc + 4'h1;
      end else begin
        n.lpc = 4'h0;
        if (s.sub != lcd_pkg::sub_last(t.cc)) begin
          n.sub = s.sub + 2'h1;
        end else begin
          n.sub = 2'h0;
          n.slot = 1'b1;
          if (s.com >= t.cc) begin
            n.com = 2'h0;
            n.odd = ~s.odd;
          end else begin
            n.com = s.com + 2'h1;
          end
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs come from the counters; the half-slot bit drives Type-A phase.
  assign t.slot_start = s.slot;
  assign t.com_idx = s.com;
  assign t.sub_hi = (t.cc == 2'h0) ? s.sub[1] : s.sub[0];
  assign t.frame_odd = s.odd;

endmodule : lcd_frame_timer
`default_nettype wire

// >>> tb/lcd_glass_model.sv
// Behavioural glass panel that watches the common and segment drive.
// Assumes the drive is sampled on the block's clock.
`timescale 1ns/100ps
`default_nettype none
module lcd_glass_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Drive from the block.
  input wire logic [47:0] seg,
  input wire logic [3:0] com,
  input wire logic drive_min,
  // What the glass saw.
  output logic [15:0] frames,
  output logic bad
);
  logic first_common_line_last;

  // ==============================
  // Frame count and drive sanity; cleared by the same reset as the chip.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frames <= 16'h0000;
      first_common_line_last <= 1'b0;
      bad <= 1'b0;
    end else begin
      first_common_line_last <= com[0];
      if (com[0] && !first_common_line_last) begin
        frames <= frames + 16'h0001;
      end
      if (drive_min && (seg != 48'h0000_0000_0000 || com != 4'h0)) begin
        bad <= 1'b1;
      end
      if (!$onehot0(com)) begin
        bad <= 1'b1;
      end
    end
  end
endmodule : lcd_glass_model
`default_nettype wire

// >>> tb/test_lcd_frame_sync.sv
// Self-checking bench for the LCD frame sync block.
// Assumes lcd_pkg, the timing carrier and the glass model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_lcd_frame_sync;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [5:0] ADDR = 6'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic SLEEP = 1'b0;
  logic [7:0] RDATA;
  logic [47:0] SEG_OUT;
  logic [3:0] COM_OUT;
  logic WAVE_POL, DRIVE_MIN, FRAME_IRQ, FRAME_IRQ_HIPRI, SOFT_CONTRAST;
  logic [15:0] frames, f0;
  logic bad;
  logic [7:0] rv;
  int err_count = 0;
  int num_checks = 0;
  // Rows: address, written byte, byte read back.
  logic [21:0] rows [0:8] = '{
    {lcd_pkg::A_PS, 8'hFF, 8'hDF}, {lcd_pkg::A_REG, 8'hFF, 8'h7F},
    {lcd_pkg::A_IRQE, 8'hFF, 8'h40}, {lcd_pkg::A_IRQP, 8'hFF, 8'h40},
    {lcd_pkg::A_SEGE, 8'hFF, 8'hFF}, {lcd_pkg::A_PIX, 8'hA5, 8'hA5},
    {6'h3F, 8'hFF, 8'h00}, {lcd_pkg::A_CTL, 8'h4F, 8'h4F}, {lcd_pkg::A_IRQF, 8'hFF, 8'h00}};

  // ==============================
  // Clock, design and glass.
  always #20 CLOCK = ~CLOCK;
  lcd_frame_sync dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .SEG_OUT(SEG_OUT), .COM_OUT(COM_OUT),
    .WAVE_POL(WAVE_POL), .DRIVE_MIN(DRIVE_MIN), .FRAME_IRQ(FRAME_IRQ),
    .FRAME_IRQ_HIPRI(FRAME_IRQ_HIPRI), .SOFT_CONTRAST(SOFT_CONTRAST));
  lcd_glass_model glass_u (.clock(CLOCK), .rst_n(RST_N), .seg(SEG_OUT), .com(COM_OUT),
    .drive_min(DRIVE_MIN), .frames(frames), .bad(bad));

  // ==============================
  // Register port and waiting helpers.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cyc

  // Bounded wait for the interrupt, or for one common to be active.
  task automatic wait_for(input logic [3:0] com, input logic irq);
    int n;
    n = 0;
    while (!(irq ? FRAME_IRQ === 1'b1 : COM_OUT === com) && n < 20000) begin
      cyc(1);
      n++;
    end
    if (n >= 20000) begin
      err_count++;
      test_done();
    end
  endtask : wait_for

  // Setup in the order software must keep; the block is off meanwhile.
  task automatic cfg(input logic [7:0] ps, input logic [7:0] ctl);
    wr(lcd_pkg::A_CTL, 8'h00);
    wr(lcd_pkg::A_PS, ps);
    for (int i = 0; i < 6; i++) wr(6'(lcd_pkg::A_SEGE + i), 8'hFF);
    wr(lcd_pkg::A_CTL, ctl);
    for (int i = 0; i < 24; i++) wr(6'(lcd_pkg::A_PIX + i), 8'h5A);
    wr(lcd_pkg::A_REG, 8'h00);
    wr(lcd_pkg::A_IRQF, 8'h00);
    wr(lcd_pkg::A_IRQE, 8'h40);
    wr(lcd_pkg::A_CTL, ctl | 8'h80);
  endtask : cfg

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ==============================
  // Main sequence.
  initial begin
    repeat (3) @(posedge CLOCK);
    RST_N <= 1'b1;
    rd(lcd_pkg::A_CTL, rv);
    `CHK(rv, 8'h00)
    `CHK({DRIVE_MIN, COM_OUT}, 5'h10)
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][21:16], rows[i][15:8]);
      rd(rows[i][21:16], rv);
      `CHK(rv, rows[i][7:0])
    end
    `CHK({FRAME_IRQ_HIPRI, SOFT_CONTRAST}, 2'h2)
    wr(lcd_pkg::A_REG, 8'h00);
    cyc(2);
    `CHK(SOFT_CONTRAST, 1'b1)
    $display("test registers done");
    // Type-A and Type-B static never raise the frame flag.
    cfg(8'h00, 8'h0F);
    f0 = frames;
    cyc(8000);
    `CHK(frames - f0 > 16'h0001, 1'b1)
    rd(lcd_pkg::A_IRQF, rv);
    `CHK(rv, 8'h00)
    cfg(8'h80, 8'h0C);
    cyc(8000);
    rd(lcd_pkg::A_IRQF, rv);
    `CHK(rv, 8'h00)
    $display("test no flag done");
    // Type-B quarter drive: flag in the last slot, window, late write.
    cfg(8'h80, 8'h0F);
    wait_for(4'h0, 1'b1);
    `CHK(COM_OUT, 4'h8)
    wr(lcd_pkg::A_PIX, 8'hC3);
    rd(lcd_pkg::A_PIX, rv);
    `CHK(rv, 8'hC3)
    rd(lcd_pkg::A_CTL, rv);
    `CHK(rv, 8'h8F)
    wait_for(4'h1, 1'b0);
    `CHK(SEG_OUT[7:0] ^ {8{WAVE_POL}}, 8'hC3)
    wr(lcd_pkg::A_PIX, 8'h3C);
    rd(lcd_pkg::A_PIX, rv);
    `CHK(rv, 8'hC3)
    cyc(900);
    rd(lcd_pkg::A_CTL, rv);
    `CHK(rv, 8'hAF)
    rd(lcd_pkg::A_IRQF, rv);
    `CHK(rv, 8'h40)
    wr(lcd_pkg::A_IRQE, 8'h00);
    cyc(2);
    `CHK(FRAME_IRQ, 1'b0)
    wr(lcd_pkg::A_IRQF, 8'h00);
    rd(lcd_pkg::A_IRQF, rv);
    `CHK(rv, 8'h00)
    wr(lcd_pkg::A_CTL, 8'h8F);
    rd(lcd_pkg::A_CTL, rv);
    `CHK(rv, 8'h8F)
    $display("test frame flag done");
    // Sleep with sleep-enable set, entered just after a boundary.
    wr(lcd_pkg::A_CTL, 8'hCF);
    wait_for(4'h1, 1'b0);
    @(posedge CLOCK);
    SLEEP <= 1'b1;
    cyc(2);
    `CHK({DRIVE_MIN, COM_OUT, SEG_OUT}, 53'h10_0000_0000_0000)
    wr(6'(lcd_pkg::A_PIX + 1), 8'hFF);
    rd(6'(lcd_pkg::A_PIX + 1), rv);
    `CHK(rv, 8'h5A)
    rd(lcd_pkg::A_CTL, rv);
    `CHK(rv, 8'hEF)
    SLEEP <= 1'b0;
    wr(lcd_pkg::A_CTL, 8'h8F);
    // Sleep-enable clear with a non-system source keeps refreshing.
    SLEEP <= 1'b1;
    f0 = frames;
    cyc(7000);
    `CHK(frames - f0 > 16'h0001, 1'b1)
    `CHK(DRIVE_MIN, 1'b0)
    SLEEP <= 1'b0;
    // System clock as source stops on Sleep even with sleep-enable clear.
    wr(lcd_pkg::A_CTL, 8'h83);
    cyc(10);
    SLEEP <= 1'b1;
    cyc(2);
    `CHK({DRIVE_MIN, COM_OUT}, 5'h10)
    SLEEP <= 1'b0;
    `CHK(bad, 1'b0)
    $display("test sleep done");
    test_done();
  end
endmodule : test_lcd_frame_sync
`default_nettype wire
